// file: hdl/dbr_pkg.sv
// Shared constants, types and helpers for the DDR3L bank, burst and refresh block.
package dbr_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_BANKS   = 8;
    localparam int BANK_W      = 3;
    localparam int ADDR_W      = 14;
    localparam int WORD_W      = 16;
    localparam int PAIR_W      = 32;
    localparam int MEM_WORDS   = 64;
    localparam int MEM_IDX_W   = 6;
    localparam int CHOP_BIT    = 12;
    localparam int AUTO_PRE_BIT = 10;
    localparam int LAT_W       = 5;
    localparam int LAT_DEPTH   = 32;
    localparam int PAYLOAD_W   = 7;
    localparam int FIFO_DEPTH  = 32;
    localparam int TIMER_W     = 8;

    // ----------------------------------------------------------------
    // Command codes on {row strobe, column strobe, write enable}
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [20:0] PIN_IDLE = 21'h1e0000;

    // ----------------------------------------------------------------
    // Burst control
    // ----------------------------------------------------------------
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_OTF    = 2'h1;
    localparam logic [2:0] PAIRS_FULL   = 3'h4;
    localparam logic [2:0] PAIRS_CHOP   = 3'h2;
    localparam logic [2:0] COLUMN_TO_COLUMN_DELAY = 3'h4;
    localparam logic [LAT_W-1:0] MIN_LATENCY = 5'h02;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS         = 10;
    localparam int PRECHARGE_TIME_NS     = 15;
    localparam int REFRESH_CYCLE_TIME_NS = 160;
    localparam logic [TIMER_W-1:0] PRECHARGE_CYCLES =
        TIMER_W'((PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] REFRESH_CYCLES =
        TIMER_W'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        DBR_IDLE  = 3'h1,
        DBR_READ  = 3'h2,
        DBR_WRITE = 3'h4
    } dbr_burst_e;

    function automatic logic dbr_full_burst(input logic [1:0] mode, input logic chop);
        dbr_full_burst = (mode == BURST_FIXED8) || ((mode == BURST_OTF) && chop);
    endfunction : dbr_full_burst

    function automatic logic [MEM_IDX_W-1:0] dbr_index(input logic [BANK_W-1:0] bank,
                                                      input logic [1:0] pair,
                                                      input logic half);
        dbr_index = {bank, pair, half};
    endfunction : dbr_index

endpackage : dbr_pkg

// file: hdl/dbr_fifo.sv
// Read data FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module dbr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
        end
    end
endmodule : dbr_fifo

// file: hdl/dbr_delay_line.sv
// Variable delay line that holds read commands for the read latency.
`timescale 1ns/1ns
module dbr_delay_line
    import dbr_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 in_valid,
    input  wire logic [PAYLOAD_W-1:0] in_payload,
    input  wire logic [LAT_W-1:0]     latency,
    output logic                      out_valid,
    output logic      [PAYLOAD_W-1:0] out_payload
);
    logic [LAT_DEPTH-1:0] stage_valid;
    logic [PAYLOAD_W-1:0] stage_payload [LAT_DEPTH];
    logic [LAT_W-1:0]     tap;

    // The first stage and the engine each add one cycle, so the tap sits two short of the latency.
    assign tap         = (latency < MIN_LATENCY) ? '0 : latency - MIN_LATENCY;
    assign out_valid   = stage_valid[tap];
    assign out_payload = stage_payload[tap];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_valid <= '0;
        end else begin
            stage_valid <= {stage_valid[LAT_DEPTH-2:0], in_valid};
        end
    end

    always_ff @(posedge sys_clk) begin
        stage_payload[0] <= in_payload;
        for (int i = 1; i < LAT_DEPTH; i++) begin
            stage_payload[i] <= stage_payload[i-1];
        end
    end
endmodule : dbr_delay_line

// file: hdl/dbr_core.sv
// DDR3L device bank state, burst engine, read latency and refresh logic.
// Operation
// RULE1 - Activate opens the addressed row in the selected bank.
// RULE2 - Controller keeps row open until precharge; precharge before another row.
// RULE3 - Precharge closes one bank or all banks, by the auto precharge bit.
// RULE4 - Controller waits the precharge time before activating that bank.
// RULE5 - Controller may access other banks during an auto precharge.
// RULE6 - A precharged bank is idle; reads and writes need an activate first.
// RULE7 - Precharge to an idle bank is accepted and restarts the timer.
// RULE8 - Chop bit low gives four beats, high gives eight; column gap four.
// RULE9 - Chop bit never forms part of the column address.
// RULE10 - Auto precharge is chosen per read or write command.
// RULE11 - Read data follows after additive plus column access latency.
// RULE12 - Eight beats when burst field is 00, or 01 with chop bit high.
// RULE13 - Controller resets the device after any general timing violation.
// RULE14 - Data setup or hold faults corrupt only the addressed location.
// RULE15 - Strobe faults corrupt only the addressed location; no hang.
// RULE16 - Refresh decodes as select, row and column strobes low, write high.
// RULE17 - Controller refreshes only with all banks idle past precharge time.
// RULE18 - Refresh rows come from an internal counter, not the address bus.
// RULE19 - After refresh all banks idle; only idle commands until cycle time.
// RULE20 - Controller averages one refresh per interval, at most eight postponed.
// RULE21 - Controller may pull in at most eight refreshes for credit.
// RULE22 - Controller flushes postponed refreshes before self-refresh.
// RULE23 - Controller tracks open rows and precharge timers per bank.
`timescale 1ns/1ns
module dbr_core
    import dbr_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              cmd_cs_n,
    input  wire logic              cmd_ras_n,
    input  wire logic              cmd_cas_n,
    input  wire logic              cmd_we_n,
    input  wire logic [BANK_W-1:0] bank_select_inputs,
    input  wire logic [ADDR_W-1:0] row_column_address_inputs,
    input  wire logic [1:0]        mode_register_zero_burst,
    input  wire logic [3:0]        additive_latency,
    input  wire logic [3:0]        column_access_latency,
    input  wire logic [PAIR_W-1:0] wr_data,
    input  wire logic              wr_valid,
    input  wire logic              wr_strobe_fault,
    output logic                   wr_ready,
    output logic      [PAIR_W-1:0] rd_data,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic      [NUM_BANKS-1:0] bank_open,
    output logic      [NUM_BANKS-1:0] bank_ready,
    output logic                   refresh_busy,
    output logic      [ADDR_W-1:0] refresh_row,
    output logic                   cmd_refused
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [20:0] pin_s1;
    logic [20:0] pin_s2;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
        end else begin
            pin_s1 <= {cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n,
                       bank_select_inputs, row_column_address_inputs};
            pin_s2 <= pin_s1;
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic              sel;
    logic [2:0]        code;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic              is_act;
    logic              is_rd;
    logic              is_wr;
    logic              is_pre;
    logic              is_ref;
    logic              auto_pre;
    logic              full_burst;
    logic [2:0]        col_start;

    assign sel        = !pin_s2[20];
    assign code       = pin_s2[19:17];
    assign ba         = pin_s2[16:14];
    assign addr       = pin_s2[13:0];
    assign is_act     = sel && (code == CMD_ACT);
    assign is_rd      = sel && (code == CMD_RD);
    assign is_wr      = sel && (code == CMD_WR);
    assign is_pre     = sel && (code == CMD_PRE);
    assign is_ref     = sel && (code == CMD_REF);                          // [RULE16]
    assign auto_pre   = addr[AUTO_PRE_BIT];                                // [RULE3] [RULE10]
    assign full_burst = dbr_full_burst(mode_register_zero_burst, addr[CHOP_BIT]); // [RULE8] [RULE12]
    assign col_start  = addr[2:0];                                         // [RULE9]

    // ----------------------------------------------------------------
    // Acceptance
    // ----------------------------------------------------------------
    dbr_burst_e        state;
    logic [TIMER_W-1:0] pre_timer [NUM_BANKS];
    logic [TIMER_W-1:0] ref_timer;
    logic [2:0]        ccd_timer;
    logic              act_ok;
    logic              rd_ok;
    logic              wr_ok;
    logic              ref_ok;
    logic              col_free;

    assign col_free = (ccd_timer == '0) && !refresh_busy;
    assign act_ok   = is_act && !bank_open[ba] && bank_ready[ba] && !refresh_busy;
    assign rd_ok    = is_rd && bank_open[ba] && col_free;                  // [RULE6]
    assign wr_ok    = is_wr && bank_open[ba] && col_free && (state == DBR_IDLE); // [RULE6]
    assign ref_ok   = is_ref && (bank_open == '0) && (bank_ready == '1) && !refresh_busy;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_refused <= 1'b0;
        end else begin
            // Precharge is taken even to an idle bank, but refused while a refresh is busy.
            cmd_refused <= (is_act && !act_ok) || (is_rd && !rd_ok) ||
                           (is_wr && !wr_ok) || (is_ref && !ref_ok) ||
                           (is_pre && refresh_busy);                       // [RULE19]
        end
    end

    // Column commands cannot come closer than the column-to-column delay.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ccd_timer <= '0;
        end else if (rd_ok || wr_ok) begin
            ccd_timer <= COLUMN_TO_COLUMN_DELAY - 3'h1;                    // [RULE8]
        end else if (ccd_timer != '0) begin
            ccd_timer <= ccd_timer - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Bank state
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] open_row [NUM_BANKS];
    logic              pre_hit  [NUM_BANKS];

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            pre_hit[b] = (is_pre && !refresh_busy && (auto_pre || (ba == BANK_W'(b)))) ||
                         ((rd_ok || wr_ok) && auto_pre && (ba == BANK_W'(b)));  // [RULE3] [RULE10]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_open <= '0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (pre_hit[b]) begin
                    bank_open[b] <= 1'b0;                                  // [RULE3]
                end else if (act_ok && (ba == BANK_W'(b))) begin
                    bank_open[b] <= 1'b1;                                  // [RULE1]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                open_row[b] <= '0;
            end
        end else if (act_ok) begin
            open_row[ba] <= addr;                                          // [RULE1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                pre_timer[b] <= '0;
            end
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (pre_hit[b]) begin
                    pre_timer[b] <= PRECHARGE_CYCLES;                      // [RULE7]
                end else if (pre_timer[b] != '0) begin
                    pre_timer[b] <= pre_timer[b] - 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_ready[b] = (pre_timer[b] == '0);
        end
    end

    // ----------------------------------------------------------------
    // Refresh
    // ----------------------------------------------------------------
    assign refresh_busy = (ref_timer != '0);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ref_timer <= '0;
        end else if (ref_ok) begin
            ref_timer <= REFRESH_CYCLES;                                   // [RULE19]
        end else if (ref_timer != '0) begin
            ref_timer <= ref_timer - 1'b1;
        end
    end

    // The address bus is ignored here; the row comes from the counter.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            refresh_row <= '0;
        end else if (ref_ok) begin
            refresh_row <= refresh_row + 1'b1;                             // [RULE18]
        end
    end

    // ----------------------------------------------------------------
    // Read latency and burst engine
    // ----------------------------------------------------------------
    logic                 lat_valid;
    logic [PAYLOAD_W-1:0] lat_payload;
    logic [LAT_W-1:0]     read_latency;
    logic [WORD_W-1:0]    mem [MEM_WORDS];
    logic [BANK_W-1:0]    eng_bank;
    logic [1:0]           eng_pair;
    logic [2:0]           pairs_left;
    logic                 push_valid;
    logic                 push_ready;
    logic                 eng_step;
    logic [MEM_IDX_W-1:0] idx_lo;
    logic [MEM_IDX_W-1:0] idx_hi;

    assign read_latency = {1'b0, additive_latency} + {1'b0, column_access_latency}; // [RULE11]

    dbr_delay_line u_delay (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .in_valid    (rd_ok),
        .in_payload  ({full_burst, ba, col_start}),
        .latency     (read_latency),
        .out_valid   (lat_valid),
        .out_payload (lat_payload)
    );

    assign idx_lo     = dbr_index(eng_bank, eng_pair, 1'b0);
    assign idx_hi     = dbr_index(eng_bank, eng_pair, 1'b1);
    assign push_valid = (state == DBR_READ);
    assign wr_ready   = (state == DBR_WRITE);
    // A read burst waits for FIFO room; a write burst never waits for data.
    assign eng_step   = (state == DBR_WRITE) || (push_valid && push_ready);

    // A latency slot that matures while a burst runs is dropped; the column spacing of four
    // does not stop this: a read four cycles after a full read burst matures in that burst.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state      <= DBR_IDLE;
            eng_bank   <= '0;
            eng_pair   <= '0;
            pairs_left <= '0;
        end else begin
            unique case (state)
                DBR_IDLE: begin
                    if (lat_valid) begin
                        state      <= DBR_READ;
                        eng_bank   <= lat_payload[5:3];
                        eng_pair   <= lat_payload[2:1];
                        pairs_left <= lat_payload[6] ? PAIRS_FULL : PAIRS_CHOP; // [RULE8]
                    end else if (wr_ok) begin
                        state      <= DBR_WRITE;
                        eng_bank   <= ba;
                        eng_pair   <= col_start[2:1];
                        pairs_left <= full_burst ? PAIRS_FULL : PAIRS_CHOP;     // [RULE12]
                    end
                end
                DBR_READ, DBR_WRITE: begin
                    if (eng_step) begin
                        eng_pair   <= eng_pair + 2'h1;
                        pairs_left <= pairs_left - 3'h1;
                        if (pairs_left == 3'h1) begin
                            state <= DBR_IDLE;                             // [RULE15]
                        end
                    end
                end
            endcase
        end
    end

    // A beat with a strobe fault is stored as received and touches only
    // its own location; the burst still ends on schedule.
    always_ff @(posedge sys_clk) begin
        if ((state == DBR_WRITE) && wr_valid) begin
            mem[idx_lo] <= wr_data[WORD_W-1:0];                            // [RULE14]
            mem[idx_hi] <= wr_data[PAIR_W-1:WORD_W];                       // [RULE14]
        end
    end

    dbr_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({mem[idx_hi], mem[idx_lo]}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking dbr_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_act_opens;
        act_ok |=> bank_open[$past(ba)] && (open_row[$past(ba)] == $past(addr));
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate did not open bank"); // [RULE1]

    property p_pre_all;
        (is_pre && auto_pre && !refresh_busy) |=> (bank_open == '0) && (bank_ready == '0);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open"); // [RULE3]

    property p_pre_idle_restart;
        (is_pre && !auto_pre && !refresh_busy) |=> !bank_ready[$past(ba)] ##1 !bank_ready[$past(ba, 2)];
    endproperty
    a_pre_idle_restart: assert property (p_pre_idle_restart) else $error("precharge timer not restarted"); // [RULE7]

    property p_rd_idle_refused;
        (is_rd && !bank_open[ba]) |=> cmd_refused;
    endproperty
    a_rd_idle_refused: assert property (p_rd_idle_refused) else $error("read to idle bank taken"); // [RULE6]

    property p_full_write;
        (wr_ok && full_burst) |=> (state == DBR_WRITE) [*4] ##1 (state == DBR_IDLE);
    endproperty
    a_full_write: assert property (p_full_write) else $error("full write burst length wrong"); // [RULE12]

    property p_chop_write;
        (wr_ok && !full_burst) |=> (state == DBR_WRITE) [*2] ##1 (state == DBR_IDLE);
    endproperty
    a_chop_write: assert property (p_chop_write) else $error("chopped write burst length wrong"); // [RULE8]

    property p_read_latency;
        (rd_ok && (read_latency == 5'h09)) |-> ##8 lat_valid;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read latency not nine"); // [RULE11]

    property p_ref_row;
        ref_ok |=> refresh_busy && (refresh_row == $past(refresh_row) + 1'b1);
    endproperty
    a_ref_row: assert property (p_ref_row) else $error("refresh row counter wrong"); // [RULE18]

    property p_ref_idle;
        refresh_busy |-> (bank_open == '0) && !$rose(state == DBR_WRITE);
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("bank open during refresh"); // [RULE19]

    property p_fault_no_hang;
        ((state == DBR_WRITE) && wr_strobe_fault) |-> ##[1:4] (state == DBR_IDLE);
    endproperty
    a_fault_no_hang: assert property (p_fault_no_hang) else $error("write burst hung on fault"); // [RULE15]

    c_act:     cover property (act_ok);
    c_read:    cover property ((state == DBR_READ) ##1 (state == DBR_IDLE));
    c_refresh: cover property (ref_ok ##1 refresh_busy);
    c_chop:    cover property (wr_ok && !full_burst);

endmodule : dbr_core

// file: verification/dbr_ctrl_model.sv
// Controller model: drives command pins and write data pairs.
`timescale 1ns/1ns
module dbr_ctrl_model
    import dbr_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 wr_ready,
    input  wire logic [NUM_BANKS-1:0] bank_ready,
    output logic      [3:0]           pins,
    output logic      [BANK_W-1:0]    bank,
    output logic      [ADDR_W-1:0]    addr,
    output logic      [PAIR_W-1:0]    wr_data,
    output logic                      wr_valid,
    output logic                      wr_strobe_fault
);
    logic [PAIR_W-1:0] wq[$];
    logic              fault = 1'b0;
    initial begin
        pins = 4'hf;
        {bank, addr, wr_valid, wr_data, wr_strobe_fault} = '0;
    end
    // Idle data is inverted so the device never sees a stale pair as fresh.
    always @(negedge sys_clk) begin
        wr_valid = wq.size() != 0;
        wr_data = wr_valid ? wq[0] : ~wr_data;
        wr_strobe_fault = fault & wr_valid;
    end
    always @(posedge sys_clk) if (wr_valid && wr_ready) void'(wq.pop_front());
    task automatic issue(input logic [2:0] op, input logic [BANK_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        for (int i = 0; i < 50 && op == CMD_ACT && !bank_ready[b]; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        pins = {1'b0, op};
        bank = b;
        addr = a;
        @(negedge sys_clk);
        pins = 4'hf;
        bank = ~b;
        addr = ~a;
    endtask : issue
endmodule : dbr_ctrl_model

// file: verification/dbr_core_tb.sv
// Self-checking bench for the bank, burst and refresh core.
`timescale 1ns/1ns
module dbr_core_tb;
    import dbr_pkg::*;
    localparam int RL = 9;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_ready = 1'b0;
    logic [1:0] mode = BURST_FIXED8;
    logic [3:0] pins;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr, rrow, refresh_row;
    logic [PAIR_W-1:0] wr_data, rd_data, mem[NUM_BANKS][4], exp_q[$];
    logic wr_valid, wr_strobe_fault, wr_ready, rd_valid, refresh_busy, cmd_refused;
    logic [NUM_BANKS-1:0] bank_open, bank_ready;
    int bad_count = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) rd_ready <= ($urandom & 3) != 0;
    dbr_ctrl_model ctl(.sys_clk, .wr_ready, .bank_ready, .pins, .bank, .addr, .wr_data,
                       .wr_valid, .wr_strobe_fault);
    dbr_core dut(.sys_clk, .rst_n, .cmd_cs_n(pins[3]), .cmd_ras_n(pins[2]),
        .cmd_cas_n(pins[1]), .cmd_we_n(pins[0]), .bank_select_inputs(bank),
        .row_column_address_inputs(addr), .mode_register_zero_burst(mode),
        .additive_latency(4'h4), .column_access_latency(4'h5), .wr_data, .wr_valid,
        .wr_strobe_fault, .wr_ready, .rd_data, .rd_valid, .rd_ready, .bank_open,
        .bank_ready, .refresh_busy, .refresh_row, .cmd_refused);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic lim(input int j, input int n);
        if (j >= n) begin
            bad_count++;
            test_done();
        end
    endtask : lim
    task automatic cmd(input logic [2:0] op, input int b, input logic [13:0] a, input logic no);
        logic seen;
        seen = 1'b0;
        ctl.issue(op, b[2:0], a);
        repeat (4) begin
            @(negedge sys_clk);
            seen |= cmd_refused;
        end
        check("cmd_refused", seen, no);
    endtask : cmd
    task automatic wr(input int b, input logic [13:0] a, input int np, input logic flt);
        logic [PAIR_W-1:0] d;
        ctl.fault = flt;
        for (int i = 0; i < np; i++) begin
            d = $urandom;
            mem[b][(a[2:1] + i) % 4] = d;
            ctl.wq.push_back(d);
        end
        cmd(CMD_WR, b, a, 1'b0);
        repeat (4) @(negedge sys_clk);
        check("write_pairs", ctl.wq.size(), 0);
        ctl.fault = 1'b0;
    endtask : wr
    task automatic rd(input int b, input logic [13:0] a, input int np);
        int j;
        for (int i = 0; i < np; i++) exp_q.push_back(mem[b][(a[2:1] + i) % 4]);
        ctl.issue(CMD_RD, b[2:0], a);
        for (j = 0; j < 40 && rd_valid !== 1'b1; j++) @(negedge sys_clk);
        lim(j, 40);
        check("read_latency", j inside {[RL + 2:RL + 3]}, 1);
        for (j = 0; j < 99 && exp_q.size() != 0; j++) @(negedge sys_clk);
        lim(j, 99);
        repeat (4) @(negedge sys_clk);
    endtask : rd
    always @(posedge sys_clk) if (rst_n && rd_valid === 1'b1 && rd_ready) begin
        if (exp_q.size() == 0) check("rd_extra", 1, 0);
        else check("rd_data", rd_data, exp_q.pop_front());
    end
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(72));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        cmd(CMD_ACT, 1, 14'h0123, 1'b0);
        cmd(CMD_ACT, 2, 14'h0456, 1'b0);
        check("bank_open", bank_open, 8'h06);
        wr(1, 14'h0000, 4, 1'b0);
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            rd(1, 14'h1002, m < 2 ? 4 : 2);
        end
        mode = BURST_OTF;
        rd(1, 14'h0004, 2);
        wr(2, 14'h0006, 2, 1'b0);
        rd(2, 14'h0006, 2);
        cmd(CMD_RD, 5, 14'h1000, 1'b1);
        $display("Test bursts done");
        cmd(CMD_PRE, 2, 14'h0000, 1'b0);
        check("bank_open", bank_open, 8'h02);
        cmd(CMD_PRE, 2, 14'h0000, 1'b0);
        cmd(CMD_PRE, 0, 14'h0400, 1'b0);
        check("bank_open", bank_open, 8'h00);
        cmd(CMD_RD, 1, 14'h1000, 1'b1);
        $display("Test precharge done");
        mode = BURST_FIXED8;
        cmd(CMD_ACT, 3, 14'h0010, 1'b0);
        wr(3, 14'h0400, 4, 1'b1);
        check("bank_open", bank_open, 8'h00);
        cmd(CMD_ACT, 3, 14'h0010, 1'b0);
        cmd(CMD_ACT, 1, 14'h0123, 1'b0);
        rd(3, 14'h0000, 4);
        rd(1, 14'h0000, 4);
        $display("Test auto precharge done");
        cmd(CMD_PRE, 0, 14'h0400, 1'b0);
        rrow = refresh_row;
        cmd(CMD_REF, 5, 14'($urandom), 1'b0);
        check("refresh_row", refresh_row, rrow + 14'h1);
        check("refresh_busy", refresh_busy, 1);
        cmd(CMD_ACT, 1, 14'h0000, 1'b1);
        for (int j = 0; j < 30 && refresh_busy; j++) @(negedge sys_clk);
        lim(refresh_busy ? 30 : 0, 30);
        check("bank_open", bank_open, 8'h00);
        cmd(CMD_ACT, 1, 14'h0000, 1'b0);
        $display("Test refresh done");
        test_done();
    end
endmodule : dbr_core_tb
